// File: logic/cmc_pkg.sv
// package of constants for the core memory control block
`default_nettype none
package cmc_pkg;
    // -------------------------------------------------------------
    // word and address layout
    // -------------------------------------------------------------
    localparam int DATA_W = 48;
    localparam int WORD_W = 49;
    localparam int ADDR_W = 12;
    localparam int HALF_W = 6;
    localparam int PARITY_POS = 48;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int SEG_NS = 1000;
    localparam int SEG_CYC = (SEG_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_NS = 830;
    localparam int STROBE_CYC = STROBE_NS / CLK_NS;
    // -------------------------------------------------------------
    // apb register map
    // -------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] ADDR_OFS = 8'h08;
    localparam logic [7:0] RDLO_OFS = 8'h0C;
    localparam logic [7:0] RDHI_OFS = 8'h10;
    localparam int CTRL_FULL = 0;
    localparam int CTRL_LOWER = 1;
    localparam int CTRL_UPPER_OFF = 2;
    localparam int CTRL_MANUAL = 3;
    localparam logic [3:0] CTRL_RST = 4'h1;
endpackage : cmc_pkg
`default_nettype wire

// File: logic/cmc_addr_if.sv
// interface carrying address count controls between the top and the counter
`default_nettype none
interface cmc_addr_if;
    logic inc;
    logic lower_count_enable;
    logic upper_enable;
    logic upper_count_driver;
    logic [11:0] addr;
    modport ctl (output inc, output lower_count_enable, output upper_enable,
                 input upper_count_driver, input addr);
    modport cnt (input inc, input lower_count_enable, input upper_enable,
                 output upper_count_driver, output addr);
endinterface : cmc_addr_if
`default_nettype wire

// File: logic/cmc_addr_cnt.sv
// twelve-bit address counter with split lower and upper halves
`default_nettype none
module cmc_addr_cnt (
    input wire logic clk,
    input wire logic rst_n,
    cmc_addr_if.cnt a
);
    typedef struct packed {
        logic [11:0] addr;
    } cmc_cnt_s;
    cmc_cnt_s st_ff;
    cmc_cnt_s nxt_st;
    logic carry;
    logic lower_all_ones;

    // upper half steps on carry, or alone when the lower half is held
    always_comb begin
        lower_all_ones = &st_ff.addr[5:0];
        carry = a.inc && (!a.lower_count_enable || lower_all_ones);
        nxt_st = st_ff;
        if (a.inc && a.lower_count_enable) begin
            nxt_st.addr[5:0] = st_ff.addr[5:0] + 6'h01;
        end
        if (carry && a.upper_enable) begin
            nxt_st.addr[11:6] = st_ff.addr[11:6] + 6'h01;
        end
    end
    assign a.upper_count_driver = carry && a.upper_enable;
    assign a.addr = st_ff.addr;

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    wrap_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (a.inc && a.lower_count_enable && a.upper_enable && a.addr == 12'hFFF)
        |=> a.addr == 12'h000) else $error("address did not wrap");
    upper_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
        (a.inc && a.lower_count_enable && &a.addr[5:0]) |-> a.upper_count_driver == a.upper_enable)
        else $error("upper carry wrong");
    upper_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !a.upper_enable |=> $stable(a.addr[11:6])) else $error("upper half moved");
endmodule : cmc_addr_cnt
`default_nettype wire

// File: logic/cmc_sync.sv
// one-cycle pulse from an operator switch level
`default_nettype none
module cmc_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic pulse
);
    typedef struct packed {
        logic prev;
    } cmc_sync_s;
    cmc_sync_s st_ff;
    cmc_sync_s nxt_st;

    // remember last level, pulse on rise
    always_comb begin
        nxt_st.prev = level;
    end
    assign pulse = level && !st_ff.prev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    one_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        pulse |=> !pulse) else $error("step pulse too long");
endmodule : cmc_sync
`default_nettype wire

// File: logic/cmc_core_ctrl.sv
// core memory read/write and address step control
// Functional notes
// - step switch in local gives one-cycle pulse
// - increment is step OR gated four-input group
// - worst-case flag blocks the gated address increments, not the step
// - manual mode steps address at count three
// - auto mode steps when write flag set
// - extra gates qualified by count zero-or-three
// - lower half held: increment drives upper half
// - upper half counts as carry from lower
// - upper count needs switch enable, default on
// - start and write request form input strobe
// - even data sets parity bit at strobe
// - parity bit odd, not sent on READ_DATA
// - zero bits enable inhibit during write phase
// - read loads nothing and leaves write flag
// - sense strobe sets bits, suppressed on write
// - offer data bits and odd parity check
// - register held until cycle end, then cleared
// - every access runs read then write phase
// - four one-microsecond segments, counter rests zero
// - local address counts 0000 to 7777 wrapping
//
// Local design decisions: the APB register port and the placing of the registers.
`default_nettype none
module cmc_core_ctrl #(
    parameter int SEG_CYC = cmc_pkg::SEG_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic REMOTE_MODE_LEVEL,
    input wire logic CYCLE_START_LEVEL,
    input wire logic WRITE_REQUEST_LEVEL,
    input wire logic [47:0] WRITE_DATA_LINES,
    input wire logic [48:0] SENSE_AMPLIFIER,
    input wire logic ADDRESS_ADVANCE_SWITCH,
    input wire logic LOCAL_START,
    input wire logic WORST_CASE_DONE,
    input wire logic AUTO_SELECT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [47:0] READ_DATA,
    output logic PARITY_OK,
    output logic [48:0] INHIBIT_DRIVE,
    output logic [1:0] PULSE_COUNT,
    output logic [11:0] ADDRESS,
    output logic ADDRESS_INCREMENT_DRIVER
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pc;
        logic [15:0] seg;
        logic write_operation_flag;
        logic [48:0] information_register;
        logic local_start_flag;
        logic worst_case_flag;
        logic [3:0] ctrl;
        logic [31:0] rdata;
    } cmc_ctl_s;
    cmc_ctl_s st_ff;
    cmc_ctl_s nxt_st;
    // strobe offset scaled to the segment length; must stay above zero so idle never strobes
    localparam int STROBE_SEG = cmc_pkg::STROBE_CYC * SEG_CYC / cmc_pkg::SEG_CYC;

    cmc_addr_if aif();
    logic step_increment_level;
    logic input_strobe;
    logic start_ok;
    logic seg_end;
    logic counter_zero_or_three;
    logic strobe_timing_pulse;
    logic read_sense_strobe;
    logic inhibit_timing;
    logic information_clear_driver;
    logic parity_fault_level;
    logic shunt;
    logic group_or;
    logic apb_wr;
    logic apb_rd;
    logic [31:0] rd_mux;
    logic manual_select_level;
    logic full_count_enable;

    // odd-parity check: true when count of ones is odd
    function automatic logic odd_ones(input logic [48:0] w);
        odd_ones = ^w;
    endfunction : odd_ones

    // ---------------------------------------------------------------
    // operator synchroniser and address counter
    // ---------------------------------------------------------------
    cmc_sync u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .level(ADDRESS_ADVANCE_SWITCH && !REMOTE_MODE_LEVEL),
        .pulse(step_increment_level)
    );
    cmc_addr_cnt u_cnt (
        .clk(MCLK),
        .rst_n(RST_N),
        .a(aif.cnt)
    );

    // ---------------------------------------------------------------
    // timing decode from the pulse counter
    // ---------------------------------------------------------------
    always_comb begin
        seg_end = (st_ff.seg == 16'(SEG_CYC - 1));
        start_ok = (st_ff.pc == 2'h0) && CYCLE_START_LEVEL;
        input_strobe = start_ok && REMOTE_MODE_LEVEL && WRITE_REQUEST_LEVEL;
        counter_zero_or_three = (st_ff.pc == 2'h0) || (st_ff.pc == 2'h3);
        // strobe about 830 ns into the running first segment stands in for the delay timer
        strobe_timing_pulse = (st_ff.pc == 2'h0) &&
                              (st_ff.seg == 16'(STROBE_SEG));
        read_sense_strobe = strobe_timing_pulse && !st_ff.write_operation_flag;
        inhibit_timing = st_ff.pc[1];
        information_clear_driver = (st_ff.pc == 2'h3) && seg_end;
        parity_fault_level = !odd_ones({1'b0, st_ff.information_register[47:0]});
    end

    // ---------------------------------------------------------------
    // address increment gating
    // ---------------------------------------------------------------
    always_comb begin
        manual_select_level = st_ff.ctrl[cmc_pkg::CTRL_MANUAL];
        full_count_enable = st_ff.ctrl[cmc_pkg::CTRL_FULL];
        shunt = full_count_enable && st_ff.local_start_flag && !st_ff.worst_case_flag;
        group_or = (st_ff.pc == 2'h3 && manual_select_level && seg_end) ||
                   (!manual_select_level && st_ff.write_operation_flag && seg_end
                    && st_ff.pc == 2'h3) ||
                   (!manual_select_level && counter_zero_or_three && st_ff.seg == 16'h0000
                    && st_ff.pc == 2'h0 && st_ff.write_operation_flag) ||
                   (manual_select_level && counter_zero_or_three && st_ff.seg == 16'h0000
                    && st_ff.pc == 2'h0 && AUTO_SELECT);
        ADDRESS_INCREMENT_DRIVER = step_increment_level ||
                                   (group_or && shunt && !REMOTE_MODE_LEVEL);
    end
    assign aif.inc = ADDRESS_INCREMENT_DRIVER;
    assign aif.lower_count_enable = st_ff.ctrl[cmc_pkg::CTRL_LOWER];
    assign aif.upper_enable = !st_ff.ctrl[cmc_pkg::CTRL_UPPER_OFF];

    // ---------------------------------------------------------------
    // apb slave, zero wait states
    // ---------------------------------------------------------------
    always_comb begin
        apb_wr = PSEL && PENABLE && PWRITE;
        apb_rd = PSEL && !PENABLE && !PWRITE;
        unique case (PADDR)
            cmc_pkg::CTRL_OFS: rd_mux = {28'h000_0000, st_ff.ctrl};
            cmc_pkg::STAT_OFS: rd_mux = {24'h00_0000, 1'b0, odd_ones(st_ff.information_register),
                                         st_ff.worst_case_flag, st_ff.local_start_flag,
                                         st_ff.write_operation_flag, 1'b0, st_ff.pc};
            cmc_pkg::ADDR_OFS: rd_mux = {20'h0_0000, aif.addr};
            cmc_pkg::RDLO_OFS: rd_mux = st_ff.information_register[31:0];
            cmc_pkg::RDHI_OFS: rd_mux = {16'h0000, st_ff.information_register[47:32]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(PADDR inside {cmc_pkg::CTRL_OFS, cmc_pkg::STAT_OFS,
                     cmc_pkg::ADDR_OFS, cmc_pkg::RDLO_OFS, cmc_pkg::RDHI_OFS});
    assign PRDATA = st_ff.rdata;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (apb_rd) begin
            nxt_st.rdata = rd_mux;
        end
        if (apb_wr && PADDR == cmc_pkg::CTRL_OFS) begin
            nxt_st.ctrl = PWDATA[3:0];
        end
        // local start and worst case flags from the maintenance panel
        if (!REMOTE_MODE_LEVEL && LOCAL_START && st_ff.pc == 2'h0) begin
            nxt_st.local_start_flag = 1'b1;
            nxt_st.worst_case_flag = !AUTO_SELECT ? 1'b0 : !WORST_CASE_DONE;
        end else if (REMOTE_MODE_LEVEL || !LOCAL_START) begin
            nxt_st.local_start_flag = 1'b0;
        end
        if (WORST_CASE_DONE) begin
            nxt_st.worst_case_flag = 1'b0;
        end
        // pulse counter: four segments, rests at zero
        if (st_ff.pc == 2'h0 && !(start_ok && REMOTE_MODE_LEVEL) &&
            !(st_ff.local_start_flag && !REMOTE_MODE_LEVEL)) begin
            nxt_st.seg = 16'h0000;
        end else if (seg_end) begin
            nxt_st.seg = 16'h0000;
            nxt_st.pc = st_ff.pc + 2'h1;
        end else begin
            nxt_st.seg = st_ff.seg + 16'h0001;
        end
        if (input_strobe) begin
            nxt_st.write_operation_flag = 1'b1;
            nxt_st.information_register[47:0] = WRITE_DATA_LINES;
        end
        if (strobe_timing_pulse && st_ff.write_operation_flag && REMOTE_MODE_LEVEL &&
            parity_fault_level) begin
            nxt_st.information_register[cmc_pkg::PARITY_POS] = 1'b1;
        end
        if (read_sense_strobe) begin
            nxt_st.information_register = st_ff.information_register | SENSE_AMPLIFIER;
        end
        if (information_clear_driver) begin
            nxt_st.information_register = '0;
            nxt_st.write_operation_flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            st_ff <= '0;
            st_ff.ctrl <= cmc_pkg::CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign READ_DATA = st_ff.information_register[47:0];
    assign PARITY_OK = odd_ones(st_ff.information_register);
    assign INHIBIT_DRIVE = inhibit_timing ? ~st_ff.information_register : 49'h0;
    assign PULSE_COUNT = st_ff.pc;
    assign ADDRESS = aif.addr;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence seg_done_s;
        seg_end;
    endsequence
    strobe_load_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        input_strobe |=> (st_ff.write_operation_flag && READ_DATA == $past(WRITE_DATA_LINES)))
        else $error("write data not loaded");
    read_noload_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (start_ok && !WRITE_REQUEST_LEVEL && !st_ff.write_operation_flag)
        |=> !st_ff.write_operation_flag) else $error("read set write flag");
    parity_odd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_ff.pc == 2'h2 && st_ff.write_operation_flag && REMOTE_MODE_LEVEL) |-> PARITY_OK)
        else $error("written word parity not odd");
    no_sense_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        st_ff.write_operation_flag |-> !read_sense_strobe) else $error("sense strobe on write");
    inhibit_phase_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_ff.pc < 2'h2) |-> INHIBIT_DRIVE == 49'h0) else $error("inhibit outside write phase");
    clear_end_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_ff.pc == 2'h3 ##0 seg_done_s) |=> (READ_DATA == 48'h0 && st_ff.pc == 2'h0))
        else $error("register not cleared");
    worst_block_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_ff.worst_case_flag && !step_increment_level) |-> !ADDRESS_INCREMENT_DRIVER)
        else $error("increment during worst case");
    count_step_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (st_ff.pc != 2'h0 && seg_end) |=> st_ff.pc == $past(st_ff.pc) + 2'h1)
        else $error("pulse counter skipped");
endmodule : cmc_core_ctrl
`default_nettype wire

// File: tb/cmc_exch_model.sv
// far-side model of the exchange controller that opens memory cycles
`default_nettype none
module cmc_exch_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic wr,
    input wire logic [47:0] wdata,
    input wire logic [1:0] pulse_count,
    output logic start,
    output logic wreq,
    output logic [47:0] wlines
);
    timeunit 1ns;
    timeprecision 100ps;
    // start and write request rise together and stand until the counter leaves zero
    always @(posedge clk) begin
        if (!rst_n) begin
            start <= 1'b0;
            wreq <= 1'b0;
            wlines <= 48'h0000_0000_0000;
        end else if (go && !start && pulse_count == 2'h0) begin
            start <= 1'b1;
            wreq <= wr;
            wlines <= wdata;
        end else if (start && pulse_count != 2'h0) begin
            start <= 1'b0;
            wreq <= 1'b0;
            wlines <= ~wlines; // released lines carry no stale data
        end else if (!start) begin
            wlines <= ~wlines;
        end
    end
endmodule : cmc_exch_model
`default_nettype wire

// File: tb/cmc_core_ctrl_tb.sv
// self-checking bench for the core memory control block
`default_nettype none
module cmc_core_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // signals and scoreboard queues
    // ----------------------------------------------------------------
    localparam int SEG = 8;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    typedef struct {logic [31:0] v; logic [31:0] m; logic e;} cmc_apb_s;
    typedef struct {logic [47:0] d; logic p; logic [48:0] h;} cmc_mem_s;
    logic mclk = 1'b0, rst_n = 1'b0, remote = 1'b0, adv = 1'b0, lstart = 1'b0;
    logic wc_done = 1'b0, auto_sel = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go = 1'b0, wr_l = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [47:0] wdata = 48'h0000_0000_0000;
    logic [48:0] sense = 49'h0_0000_0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, parity_ok, aid, start, wreq;
    logic [47:0] read_data, wlines;
    logic [48:0] inhibit;
    logic [1:0] pc, pc_prev = 2'h0;
    logic [11:0] address, exp_a;
    int failures = 0, n_checks = 0, cyc = 0, seg_n = 0;
    bit pend = 1'b0, clr = 1'b0;
    cmc_apb_s apb_q[$];
    cmc_mem_s mem_q[$];
    logic [11:0] addr_q[$];
    cmc_apb_s ea;
    cmc_mem_s em;
    // clock generator
    always #12.5 mclk = ~mclk;
    cmc_core_ctrl #(.SEG_CYC(SEG)) i_cmc_core_ctrl (
        .MCLK(mclk), .RST_N(rst_n), .REMOTE_MODE_LEVEL(remote), .CYCLE_START_LEVEL(start),
        .WRITE_REQUEST_LEVEL(wreq), .WRITE_DATA_LINES(wlines), .SENSE_AMPLIFIER(sense),
        .ADDRESS_ADVANCE_SWITCH(adv), .LOCAL_START(lstart), .WORST_CASE_DONE(wc_done),
        .AUTO_SELECT(auto_sel), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .READ_DATA(read_data), .PARITY_OK(parity_ok),
        .INHIBIT_DRIVE(inhibit), .PULSE_COUNT(pc), .ADDRESS(address),
        .ADDRESS_INCREMENT_DRIVER(aid)
    );
    cmc_exch_model i_cmc_exch_model (
        .clk(mclk), .rst_n(rst_n), .go(go), .wr(wr_l), .wdata(wdata), .pulse_count(pc),
        .start(start), .wreq(wreq), .wlines(wlines)
    );
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // one apb transfer; the monitor compares its answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] ev, input logic [31:0] m, input logic e);
        apb_q.push_back('{ev, m, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // press and release the advance switch, expecting one increment or none
    task automatic step(input logic [11:0] na, input bit inc);
        int k;
        if (inc) addr_q.push_back(na);
        adv <= 1'b1;
        repeat (3) @(posedge mclk);
        adv <= 1'b0;
        k = 0;
        while (addr_q.size() != 0 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        repeat (3) @(posedge mclk);
        if (addr_q.size() != 0) begin
            check("step missing", 64'(1), 64'(0));
            addr_q.delete();
        end
    endtask : step
    task automatic wait_pc(input logic [1:0] v);
        int k;
        k = 0;
        while (pc !== v && k < 10 * SEG) begin
            @(posedge mclk);
            k++;
        end
        if (pc !== v) check("pulse count wait", 64'(pc), 64'(v));
    endtask : wait_pc
    // next address for one increment under the given control bits
    function automatic logic [11:0] nxt_addr(input logic [11:0] a, input logic [3:0] c);
        logic [5:0] lo;
        logic [5:0] hi;
        lo = c[1] ? a[5:0] + 6'h1 : a[5:0];
        hi = ((!c[1] || a[5:0] == 6'h3F) && !c[2]) ? a[11:6] + 6'h1 : a[11:6];
        return {hi, lo};
    endfunction : nxt_addr
    // ----------------------------------------------------------------
    // monitor: compare each observed result with the oldest note
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst_n) begin
            if (psel && penable && pready) begin
                ea = apb_q.pop_front();
                check("prdata", 64'(prdata & ea.m), 64'(ea.v & ea.m));
                check("pslverr", 64'(pslverr), 64'(ea.e));
            end
            if (pend) check("address", 64'(address), 64'(exp_a));
            pend = (aid === 1'b1);
            if (pend) begin
                if (addr_q.size() == 0) begin
                    check("spurious increment", 64'(1), 64'(0));
                    pend = 1'b0;
                end else begin
                    exp_a = addr_q.pop_front();
                end
            end
            if (pc !== pc_prev) check("pulse order", 64'(pc), 64'(2'(pc_prev + 2'h1)));
            if (pc == 2'h1 && pc_prev != 2'h1) check("early inhibit", 64'(inhibit), 64'(0));
            if (pc == 2'h2 && pc_prev != 2'h2) begin
                em = mem_q.pop_front();
                check("read data", 64'(read_data), 64'(em.d));
                check("parity", 64'(parity_ok), 64'(em.p));
                check("inhibit", 64'(inhibit), 64'(em.h));
            end
            if (pc == 2'h2) seg_n++;
            if (pc == 2'h3 && pc_prev == 2'h2) begin
                check("segment", 64'(seg_n), 64'(SEG));
                seg_n = 0;
            end
            if (clr) check("clear data", 64'(read_data), 64'(0));
            if (clr) check("clear inhibit", 64'(inhibit), 64'(0));
            clr = (pc == 2'h0 && pc_prev == 2'h3);
            pc_prev = pc;
        end
    end
    // cut a hung run short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("[FAIL] run length expected 20000 seen more");
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        logic [11:0] a;
        logic [3:0] c;
        logic [47:0] d;
        logic [47:0] r;
        logic [48:0] s;
        int i;
        void'($urandom(32'h0000_DCB8));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, cmc_pkg::CTRL_OFS, 32'h0, 32'(cmc_pkg::CTRL_RST), ALL, 1'b0);
        apb(1'b0, cmc_pkg::STAT_OFS, 32'h0, 32'h0, ALL, 1'b0);
        apb(1'b0, cmc_pkg::ADDR_OFS, 32'h0, 32'h0, ALL, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h0, ALL, 1'b1);
        apb(1'b1, 8'h40, ALL, 32'h0, 32'h0, 1'b1);
        $display("test registers done");
        a = 12'h000;
        c = cmc_pkg::CTRL_RST;
        for (i = 0; i < 214; i++) begin
            if (i >= 64 && i % 10 == 4) begin
                c = {1'($urandom), 1'($urandom), 1'($urandom % 4 != 0), 1'b1};
                apb(1'b1, cmc_pkg::CTRL_OFS, 32'(c), 32'h0, 32'h0, 1'b0);
            end
            a = nxt_addr(a, c);
            step(a, 1'b1);
        end
        apb(1'b0, cmc_pkg::ADDR_OFS, 32'h0, 32'(a), ALL, 1'b0);
        $display("test address stepping done");
        // manual, full and lower count on: the zero gate would step unless worst case blocks it
        c = 4'hB;
        apb(1'b1, cmc_pkg::CTRL_OFS, 32'(c), 32'h0, 32'h0, 1'b0);
        auto_sel <= 1'b1;
        lstart <= 1'b1;
        repeat (4) @(posedge mclk);
        lstart <= 1'b0;
        apb(1'b0, cmc_pkg::STAT_OFS, 32'h0, 32'h20, 32'h20, 1'b0);
        // the operator step bypasses the shunt gate, so it still counts
        a = nxt_addr(a, c);
        step(a, 1'b1);
        wc_done <= 1'b1;
        repeat (2) @(posedge mclk);
        wc_done <= 1'b0;
        apb(1'b0, cmc_pkg::STAT_OFS, 32'h0, 32'h0, 32'h20, 1'b0);
        a = nxt_addr(a, c);
        step(a, 1'b1);
        auto_sel <= 1'b0;
        $display("test worst case done");
        remote <= 1'b1;
        for (i = 0; i < 12; i++) begin
            d = 48'({$urandom, $urandom});
            if (i < 4) d = 48'(i);
            s = 49'({$urandom, $urandom});
            r = (i % 2 == 0) ? d : s[47:0];
            if (i % 2 == 0) mem_q.push_back('{d, 1'b1, ~{~^d, d}});
            else mem_q.push_back('{s[47:0], ^s, ~s});
            sense <= s;
            wdata <= d;
            wr_l <= (i % 2 == 0);
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            wait_pc(2'h2);
            apb(1'b0, cmc_pkg::RDLO_OFS, 32'h0, r[31:0], ALL, 1'b0);
            apb(1'b0, cmc_pkg::RDHI_OFS, 32'h0, 32'(r[47:32]), ALL, 1'b0);
            wait_pc(2'h0);
        end
        $display("test memory cycles done");
        tally_and_finish();
    end
endmodule : cmc_core_ctrl_tb
`default_nettype wire
